// ==== inc/cpag_pkg.sv ====
// package of constants for the prefetch and address generation core
package cpag_pkg;
    localparam int CPAG_SEG_W = 16;
    localparam int CPAG_OFS_W = 16;
    localparam int CPAG_PHYS_W = 20;
    localparam int CPAG_SEG_SHIFT = 4;
    localparam int CPAG_QUEUE_DEPTH = 32;
    localparam int CPAG_BYTE_W = 8;
    localparam int CPAG_NUM_REGS = 14;
    localparam logic [15:0] CPAG_CODE_SEG_RST = 16'hffff;
    localparam logic [15:0] CPAG_SEG_RST = 16'h0000;
    localparam logic [15:0] CPAG_FETCH_PTR_RST = 16'h0000;
    localparam logic [15:0] CPAG_STATUS_RST = 16'hf000;
    localparam logic [15:0] CPAG_GEN_RST = 16'h0000;
    // register file indices
    localparam logic [3:0] CPAG_R_ACC = 4'h0;
    localparam logic [3:0] CPAG_R_CNT = 4'h1;
    localparam logic [3:0] CPAG_R_DAT = 4'h2;
    localparam logic [3:0] CPAG_R_BASE = 4'h3;
    localparam logic [3:0] CPAG_R_SP = 4'h4;
    localparam logic [3:0] CPAG_R_BP = 4'h5;
    localparam logic [3:0] CPAG_R_SRC = 4'h6;
    localparam logic [3:0] CPAG_R_DST = 4'h7;
    // segment selects
    localparam logic [1:0] CPAG_SEG_EXTRA = 2'h0;
    localparam logic [1:0] CPAG_SEG_CODE = 2'h1;
    localparam logic [1:0] CPAG_SEG_STACK = 2'h2;
    localparam logic [1:0] CPAG_SEG_DATA = 2'h3;
    // offset source selects
    localparam logic [1:0] CPAG_OFS_REG = 2'h0;
    localparam logic [1:0] CPAG_OFS_REGPAIR = 2'h1;
    localparam logic [1:0] CPAG_OFS_IMM = 2'h2;
    localparam logic [1:0] CPAG_OFS_REG_IMM = 2'h3;
    // alu operations
    localparam logic [2:0] CPAG_ALU_MOV = 3'h0;
    localparam logic [2:0] CPAG_ALU_ADD = 3'h1;
    localparam logic [2:0] CPAG_ALU_SUB = 3'h2;
    localparam logic [2:0] CPAG_ALU_AND = 3'h3;
    localparam logic [2:0] CPAG_ALU_OR = 3'h4;
    localparam logic [2:0] CPAG_ALU_XOR = 3'h5;
    // bus unit states, one-hot
    typedef enum logic [2:0] {
        CPAG_BUS_IDLE = 3'b001,
        CPAG_BUS_FETCH = 3'b010,
        CPAG_BUS_OPER = 3'b100
    } cpag_bus_e;
endpackage : cpag_pkg

// ==== rtl/cpag_fifo.sv ====
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module cpag_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];   // storage cells
    logic [AW-1:0] wr_q;               // write index
    logic [AW-1:0] rd_q;               // read index
    logic [AW:0] cnt_q;                // occupancy
    logic push;
    logic pop;
    // compare at count width: a depth of 2**AW does not fit in AW bits
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_q];
    assign count_o = cnt_q;
    // storage, no reset needed on data
    always_ff @(posedge clock_i)
    begin
        if (push && !flush_i)
        begin
            mem_q[wr_q] <= in_data_i;
        end
    end
    // pointers and count; flush wins over push and pop, reset wins over flush
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else if (flush_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop)
            begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : cpag_fifo
`default_nettype wire

// ==== rtl/cpag_core.sv ====
// execution unit and bus interface unit joined by a prefetch queue
// Operation
// RL1: physical address is segment shifted four plus offset
// RL2: carry out of twenty bits is dropped
// RL3: offset from registers, fetch pointer or immediate
// RL4: opcode bytes come from queue head
// RL5: execution stalls while queue is empty
// RL6: bus unit prefetches sequential bytes while executing
// RL7: execution proceeds while queue holds bytes
// RL8: fetch and execution run independently
// RL9: sixteen or eight bit data bus variants
// RL10: execution unit requests operand cycles from bus unit
// RL11: only bus unit runs external cycles
// RL12: execution unit addresses are sixteen bits
// RL13: alu does byte and word operations
// RL14: fourteen sixteen-bit registers, general halves usable; byte ops here reach only the low half of a register
// RL15: operand data passes over internal alu bus; write data here is latched straight from the register
// RL16: reset clears fetch pointer
// RL17: reset loads code segment ffff, others zero
// RL18: pointer change flushes queue and restarts fetch
`timescale 1ns/10ps
`default_nettype none
module cpag_core
    import cpag_pkg::*;
#(
    parameter int WIDE_BUS = 1   // 1: 16-bit data bus, 0: 8-bit
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    // external bus, request/done handshake
    output logic bus_req_o,
    output logic bus_write_o,
    output logic bus_fetch_o,
    output logic [19:0] bus_addr_o,
    output logic [15:0] bus_wdata_o,
    output logic [1:0] bus_lane_en_o,
    input wire logic bus_done_i,
    input wire logic [15:0] bus_rdata_i,
    // execution control from the sequencer outside
    output logic op_byte_valid_o,
    output logic [7:0] op_byte_o,
    input wire logic op_byte_take_i,
    input wire logic exec_valid_i,
    input wire logic [2:0] exec_alu_op_i,
    input wire logic exec_byte_i,
    input wire logic [3:0] exec_dst_i,
    input wire logic [3:0] exec_src_i,
    input wire logic [15:0] exec_imm_i,
    input wire logic exec_use_imm_i,
    input wire logic mem_req_i,
    input wire logic mem_write_i,
    input wire logic mem_byte_i,
    input wire logic [1:0] mem_seg_i,
    input wire logic [1:0] mem_ofs_sel_i,
    input wire logic [3:0] mem_reg_a_i,
    input wire logic [3:0] mem_reg_b_i,
    input wire logic [3:0] mem_data_reg_i,
    output logic mem_done_o,
    input wire logic jump_i,
    input wire logic [15:0] jump_ofs_i,
    input wire logic seg_wr_i,
    input wire logic [1:0] seg_sel_i,
    input wire logic [15:0] seg_wdata_i,
    output logic [15:0] fetch_pointer_o,
    output logic [15:0] status_word_o,
    output logic [5:0] queue_count_o
);
    // ==========================================================
    // register state
    // ==========================================================
    logic [15:0] gen_q [8];           // general plus pointer/index
    logic [15:0] seg_q [4];           // segment bases
    logic [15:0] fetch_pointer_q;     // next prefetch offset
    logic [15:0] status_word_q;       // flags
    cpag_bus_e bus_q;                 // bus unit state
    logic [15:0] alu_bus;             // internal alu data bus
    logic [15:0] src_val;
    logic [15:0] dst_val;
    logic [16:0] alu_res;
    logic [15:0] ofs;
    logic [19:0] phys;
    logic [15:0] sel_seg;
    logic q_in_ready;
    logic q_push;
    logic [7:0] q_byte;
    logic oper_pend_q;                // operand request latched
    logic [19:0] oper_addr_q;
    logic [15:0] oper_wdata_q;
    logic oper_write_q;
    logic oper_byte_q;
    logic [3:0] oper_reg_q;
    logic hi_pend_q;                  // second byte of 16-bit fetch
    logic [7:0] hi_byte_q;
    // ==========================================================
    // address generation
    // ==========================================================
    // offset mux: register, register pair, immediate, reg+imm
    always_comb
    begin
        case (mem_ofs_sel_i)
            CPAG_OFS_REG: ofs = gen_q[mem_reg_a_i[2:0]]; // RL3
            CPAG_OFS_REGPAIR: ofs = gen_q[mem_reg_a_i[2:0]]
                + gen_q[mem_reg_b_i[2:0]]; // RL3
            CPAG_OFS_IMM: ofs = exec_imm_i; // RL3
            default: ofs = gen_q[mem_reg_a_i[2:0]] + exec_imm_i; // RL3
        endcase
    end
    assign sel_seg = seg_q[mem_seg_i];
    // 20-bit sum, carry out simply falls off the top
    assign phys = {sel_seg, 4'h0} + {4'h0, ofs}; // RL1 RL2 RL12
    // ==========================================================
    // alu
    // ==========================================================
    assign src_val = exec_use_imm_i ? exec_imm_i
        : gen_q[exec_src_i[2:0]];
    assign dst_val = gen_q[exec_dst_i[2:0]];
    always_comb
    begin
        case (exec_alu_op_i)
            CPAG_ALU_ADD: alu_res = {1'b0, dst_val} + {1'b0, src_val};
            CPAG_ALU_SUB: alu_res = {1'b0, dst_val} - {1'b0, src_val};
            CPAG_ALU_AND: alu_res = {1'b0, dst_val & src_val};
            CPAG_ALU_OR: alu_res = {1'b0, dst_val | src_val};
            CPAG_ALU_XOR: alu_res = {1'b0, dst_val ^ src_val};
            default: alu_res = {1'b0, src_val};
        endcase
    end
    // operand read data or alu result onto the internal bus
    assign alu_bus = (bus_q == CPAG_BUS_OPER && bus_done_i)
        ? bus_rdata_i : alu_res[15:0]; // RL15
    // ==========================================================
    // general registers
    // ==========================================================
    // byte ops touch low half only; no op writes a high half on its own
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                gen_q[i] <= CPAG_GEN_RST;
            end
        end
        else if (bus_q == CPAG_BUS_OPER && bus_done_i && !oper_write_q)
        begin
            if (oper_byte_q)
            begin
                gen_q[oper_reg_q[2:0]][7:0] <= alu_bus[7:0]; // RL15
            end
            else
            begin
                gen_q[oper_reg_q[2:0]] <= alu_bus; // RL15
            end
        end
        else if (exec_valid_i)
        begin
            if (exec_byte_i)
            begin
                gen_q[exec_dst_i[2:0]][7:0] <= alu_res[7:0]; // RL13 RL14
            end
            else
            begin
                gen_q[exec_dst_i[2:0]] <= alu_res[15:0]; // RL13 RL14
            end
        end
    end
    // status word: carry, zero, sign from the last alu op
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            status_word_q <= CPAG_STATUS_RST;
        end
        else if (exec_valid_i)
        begin
            status_word_q[0] <= exec_byte_i ? (alu_res[8] ^ dst_val[8]
                ^ src_val[8]) : alu_res[16];
            status_word_q[6] <= exec_byte_i ? (alu_res[7:0] == 8'h00)
                : (alu_res[15:0] == 16'h0000);
            status_word_q[7] <= exec_byte_i ? alu_res[7] : alu_res[15];
        end
    end
    // segment bases, code segment starts at the top
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            seg_q[CPAG_SEG_EXTRA] <= CPAG_SEG_RST; // RL17
            seg_q[CPAG_SEG_CODE] <= CPAG_CODE_SEG_RST; // RL17
            seg_q[CPAG_SEG_STACK] <= CPAG_SEG_RST; // RL17
            seg_q[CPAG_SEG_DATA] <= CPAG_SEG_RST; // RL17
        end
        else if (seg_wr_i)
        begin
            seg_q[seg_sel_i] <= seg_wdata_i;
        end
    end
    // ==========================================================
    // prefetch queue
    // ==========================================================
    cpag_fifo #(
        .WIDTH(CPAG_BYTE_W),
        .DEPTH(CPAG_QUEUE_DEPTH)
    ) u_queue (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .flush_i(jump_i), // RL18
        .in_valid_i(q_push),
        .in_ready_o(q_in_ready),
        .in_data_i(q_byte),
        .out_valid_o(op_byte_valid_o), // RL5 RL7
        .out_ready_i(op_byte_take_i), // RL4
        .out_data_o(op_byte_o),
        .count_o(queue_count_o)
    );
    // high byte of a word fetch is pushed one cycle later
    assign q_push = (bus_q == CPAG_BUS_FETCH && bus_done_i) || hi_pend_q;
    assign q_byte = hi_pend_q ? hi_byte_q
        : (fetch_pointer_q[0] ? bus_rdata_i[15:8] : bus_rdata_i[7:0]);
    // ==========================================================
    // bus interface unit
    // ==========================================================
    // latch operand requests; address leaves exec side as 16 bits
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            oper_pend_q <= 1'b0;
            oper_addr_q <= 20'h00000;
            oper_wdata_q <= 16'h0000;
            oper_write_q <= 1'b0;
            oper_byte_q <= 1'b0;
            oper_reg_q <= 4'h0;
        end
        else if (mem_req_i && !oper_pend_q)
        begin
            oper_pend_q <= 1'b1; // RL10
            oper_addr_q <= phys;
            oper_wdata_q <= gen_q[mem_data_reg_i[2:0]];
            oper_write_q <= mem_write_i;
            oper_byte_q <= mem_byte_i || (WIDE_BUS == 0);
            oper_reg_q <= mem_data_reg_i;
        end
        else if (bus_q == CPAG_BUS_OPER && bus_done_i)
        begin
            oper_pend_q <= 1'b0;
        end
    end
    // operand cycles take priority; fetch runs on its own
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus_q <= CPAG_BUS_IDLE;
        end
        else
        begin
            case (bus_q)
                CPAG_BUS_IDLE:
                begin
                    if (oper_pend_q)
                    begin
                        bus_q <= CPAG_BUS_OPER; // RL11
                    end
                    else if (queue_count_o < 6'(CPAG_QUEUE_DEPTH - 2)
                        && !jump_i && !hi_pend_q)
                    begin
                        bus_q <= CPAG_BUS_FETCH; // RL6 RL8
                    end
                end
                CPAG_BUS_FETCH:
                begin
                    if (bus_done_i || jump_i)
                    begin
                        bus_q <= CPAG_BUS_IDLE;
                    end
                end
                CPAG_BUS_OPER:
                begin
                    if (bus_done_i)
                    begin
                        bus_q <= CPAG_BUS_IDLE;
                    end
                end
                default: bus_q <= CPAG_BUS_IDLE;
            endcase
        end
    end
    // fetch pointer walks sequentially, jumps reload it
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fetch_pointer_q <= CPAG_FETCH_PTR_RST; // RL16
            hi_pend_q <= 1'b0;
            hi_byte_q <= 8'h00;
        end
        else if (jump_i)
        begin
            fetch_pointer_q <= jump_ofs_i; // RL18
            hi_pend_q <= 1'b0;
        end
        else if (bus_q == CPAG_BUS_FETCH && bus_done_i)
        begin
            if (WIDE_BUS != 0 && !fetch_pointer_q[0])
            begin
                fetch_pointer_q <= fetch_pointer_q + 16'h0002; // RL9
                hi_pend_q <= 1'b1;
                hi_byte_q <= bus_rdata_i[15:8];
            end
            else
            begin
                fetch_pointer_q <= fetch_pointer_q + 16'h0001; // RL6
            end
        end
        else if (hi_pend_q)
        begin
            hi_pend_q <= 1'b0;
        end
    end
    // ==========================================================
    // bus outputs
    // ==========================================================
    assign bus_req_o = (bus_q != CPAG_BUS_IDLE); // RL11
    assign bus_write_o = (bus_q == CPAG_BUS_OPER) && oper_write_q;
    assign bus_fetch_o = (bus_q == CPAG_BUS_FETCH);
    assign bus_addr_o = (bus_q == CPAG_BUS_OPER) ? oper_addr_q
        : {seg_q[CPAG_SEG_CODE], 4'h0} + {4'h0, fetch_pointer_q}; // RL1
    assign bus_wdata_o = oper_wdata_q;
    // narrow variant uses lane 0 only
    assign bus_lane_en_o = (WIDE_BUS == 0) ? 2'b01
        : ((bus_q == CPAG_BUS_OPER && !oper_byte_q) ? 2'b11
        : (bus_addr_o[0] ? 2'b10 : 2'b01)); // RL9
    assign mem_done_o = (bus_q == CPAG_BUS_OPER) && bus_done_i;
    assign fetch_pointer_o = fetch_pointer_q;
    assign status_word_o = status_word_q;
endmodule : cpag_core
`default_nettype wire

// ==== dv/cpag_core_chk.sv ====
// checker of bus, queue and pointer timing at the core's ports
`timescale 1ns/10ps
`default_nettype none
module cpag_core_chk
    import cpag_pkg::*;
#(
    parameter int WIDE_BUS = 1   // same variant as the core
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic bus_req_o,
    input wire logic bus_write_o,
    input wire logic bus_fetch_o,
    input wire logic [19:0] bus_addr_o,
    input wire logic [1:0] bus_lane_en_o,
    input wire logic bus_done_i,
    input wire logic op_byte_valid_o,
    input wire logic jump_i,
    input wire logic mem_done_o,
    input wire logic [15:0] fetch_pointer_o,
    input wire logic [15:0] status_word_o,
    input wire logic [5:0] queue_count_o
);
    // ==========================================================
    // properties, all on the core clock
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    reset_view_a: assert property ($rose(rst_n_i) |->
        fetch_pointer_o == 16'h0000 && status_word_o == 16'hf000
        && queue_count_o == 6'h00)
        else $error("register view wrong after reset");
    first_fetch_a: assert property ($rose(rst_n_i) |-> ##[0:2]
        (bus_req_o && bus_fetch_o && bus_addr_o == 20'hffff0))
        else $error("first fetch not at start address");
    cycle_hold_a: assert property (bus_req_o && !bus_done_i
        && !(jump_i && bus_fetch_o) |=>
        bus_req_o && $stable(bus_addr_o) && $stable(bus_write_o))
        else $error("bus cycle changed before done");
    // a jump abandons an open prefetch, its data is never wanted
    jump_abort_a: assert property (jump_i && bus_fetch_o |=>
        !bus_req_o)
        else $error("prefetch not abandoned on jump");
    lane_select_a: assert property (bus_fetch_o |->
        bus_lane_en_o == ((WIDE_BUS == 0) ? 2'b01
        : (bus_addr_o[0] ? 2'b10 : 2'b01)))
        else $error("fetch byte lane wrong");
    idle_gap_a: assert property (bus_req_o && bus_done_i |=>
        !bus_req_o)
        else $error("no idle cycle between bus cycles");
    oper_done_a: assert property (mem_done_o |->
        bus_done_i && bus_req_o && !bus_fetch_o)
        else $error("operand done without operand cycle");
    head_valid_a: assert property (
        op_byte_valid_o == (queue_count_o != 6'h00))
        else $error("queue head valid disagrees with count");
    fetch_limit_a: assert property ($rose(bus_req_o) && bus_fetch_o
        |-> $past(queue_count_o) < 6'h1e)
        else $error("prefetch started with full queue");
    ptr_step_a: assert property (bus_done_i && bus_req_o
        && bus_fetch_o && !jump_i && !bus_addr_o[0] |=> fetch_pointer_o ==
        $past(fetch_pointer_o) + (WIDE_BUS ? 16'h0002 : 16'h0001))
        else $error("fetch pointer step wrong");
    jump_flush_a: assert property (jump_i |=>
        queue_count_o == 6'h00 && !op_byte_valid_o)
        else $error("queue not flushed by jump");

    // main scenarios reached
    cover property (mem_done_o && bus_write_o);
    cover property (jump_i);
    cover property (queue_count_o == 6'h1e);
endmodule : cpag_core_chk

bind cpag_core cpag_core_chk #(.WIDE_BUS(WIDE_BUS)) u_chk (.*);
`default_nettype wire

// ==== dv/cpag_mem_model.sv ====
// memory model answering the core's bus cycles with a set wait
`timescale 1ns/10ps
`default_nettype none
module cpag_mem_model (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic bus_req_o,
    input wire logic bus_write_o,
    input wire logic [19:0] bus_addr_o,
    input wire logic [15:0] bus_wdata_o,
    input wire logic [3:0] wait_i,
    output logic bus_done_i,
    output logic [15:0] bus_rdata_i,
    output logic [19:0] wr_addr_o,
    output logic [15:0] wr_data_o
);
    // ==========================================================
    // answer logic
    logic [3:0] cnt_q;   // cycles the request has waited
    logic [7:0] lo;      // byte at an address is its low address bits
    // word is even aligned, so an odd address finds its byte on lane 1
    assign lo = {bus_addr_o[7:1], 1'b0};
    // done pulses one cycle; data is scrambled outside it so a
    // late sample never sees the old word
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_q <= 4'h0;
            bus_done_i <= 1'b0;
            bus_rdata_i <= 16'h5a5a;
            wr_addr_o <= 20'h00000;
            wr_data_o <= 16'h0000;
        end
        else if (bus_done_i)
        begin
            // record writes at the edge that completes them
            bus_done_i <= 1'b0;
            cnt_q <= 4'h0;
            bus_rdata_i <= ~bus_rdata_i;
            if (bus_write_o)
            begin
                wr_addr_o <= bus_addr_o;
                wr_data_o <= bus_wdata_o;
            end
        end
        else if (bus_req_o && cnt_q >= wait_i)
        begin
            bus_done_i <= 1'b1;
            bus_rdata_i <= {lo + 8'h01, lo};
        end
        else
        begin
            cnt_q <= bus_req_o ? cnt_q + 4'h1 : 4'h0;
            bus_rdata_i <= ~bus_rdata_i;
        end
    end
endmodule : cpag_mem_model
`default_nettype wire

// ==== dv/cpu_prefetch_and_address_gen_bench.sv ====
// self-checking bench for the prefetch and address core
`timescale 1ns/10ps
`default_nettype none
module cpu_prefetch_and_address_gen_bench;
    import cpag_pkg::*;
    // ==========================================================
    // signals, named as the ports they meet
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic bus_req_o, bus_write_o, bus_fetch_o, bus_done_i;
    logic [19:0] bus_addr_o, wr_addr_o;
    logic [15:0] bus_wdata_o, bus_rdata_i, wr_data_o;
    logic [15:0] fetch_pointer_o, status_word_o;
    logic [1:0] bus_lane_en_o;
    logic op_byte_valid_o, mem_done_o;
    logic [7:0] op_byte_o;
    logic [5:0] queue_count_o;
    logic [3:0] wait_i = 4'h0;   // memory wait states
    logic op_byte_take_i = 1'b0, exec_valid_i = 1'b0, jump_i = 1'b0;
    logic exec_byte_i = 1'b0, exec_use_imm_i = 1'b0, seg_wr_i = 1'b0;
    logic mem_req_i = 1'b0, mem_write_i = 1'b0, mem_byte_i = 1'b0;
    logic [2:0] exec_alu_op_i = 3'h0;
    logic [3:0] exec_dst_i = 4'h0, exec_src_i = 4'h0, mem_reg_a_i = 4'h0;
    logic [3:0] mem_reg_b_i = 4'h0, mem_data_reg_i = 4'h0;
    logic [15:0] exec_imm_i = 16'h0000, jump_ofs_i = 16'h0000;
    logic [15:0] seg_wdata_i = 16'h0000;
    logic [1:0] mem_seg_i = 2'h0, mem_ofs_sel_i = 2'h0, seg_sel_i = 2'h0;
    logic [15:0] ofs [4] = '{16'hfff8, 16'h00f8, 16'h0020, 16'h0018};
    int mismatches = 0;
    int cmp_count = 0;

    always #10 clock_i = ~clock_i;
    cpag_core #(.WIDE_BUS(1)) dut (.*);
    cpag_mem_model mem (.*);

    // ==========================================================
    // shared tasks
    task automatic results();
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    task automatic chk(input string what, input logic [19:0] exp,
                       input logic [19:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : chk

    // a wait that ran out ends the run
    task automatic bound(input int i, input int n);
        if (i >= n)
        begin
            chk("wait bound", 20'h0, 20'h1);
            results();
        end
    endtask : bound

    // take cnt bytes from the queue head, stalling while it is empty
    task automatic take_bytes(input logic [7:0] first, input int cnt);
        int i;
        int n;
        logic [7:0] exp;
        exp = first;
        n = 0;
        op_byte_take_i = 1'b1;
        for (i = 0; i < 600 && n < cnt; i++)
        begin
            @(negedge clock_i);
            if (op_byte_valid_o === 1'b1)
            begin
                chk("opcode byte", 20'(exp), 20'(op_byte_o));
                exp++;
                n++;
            end
        end
        // let the edge pass that pops the last byte counted
        @(negedge clock_i);
        op_byte_take_i = 1'b0;
        bound(i, 600);
    endtask : take_bytes

    // one alu strobe with an immediate source
    task automatic exec(input logic [2:0] op, input logic [3:0] dst,
                        input logic byt, input logic [15:0] imm);
        @(negedge clock_i);
        exec_valid_i = 1'b1;
        exec_alu_op_i = op;
        exec_dst_i = dst;
        exec_src_i = dst;
        exec_byte_i = byt;
        exec_imm_i = imm;
        exec_use_imm_i = 1'b1;
        @(negedge clock_i);
        exec_valid_i = 1'b0;
    endtask : exec

    // operand cycle in the data segment, held until done is taken
    task automatic oper(input logic wr, input logic [1:0] sel,
                        input logic [3:0] dreg, input logic [19:0] ea,
                        input logic [15:0] ed);
        int i;
        @(negedge clock_i);
        mem_req_i = 1'b1;
        mem_write_i = wr;
        mem_seg_i = CPAG_SEG_DATA;
        mem_ofs_sel_i = sel;
        mem_reg_a_i = CPAG_R_BASE;
        mem_reg_b_i = CPAG_R_SRC;
        mem_data_reg_i = dreg;
        exec_imm_i = 16'h0020;
        for (i = 0; i < 100 && mem_done_o !== 1'b1; i++)
            @(negedge clock_i);
        bound(i, 100);
        @(negedge clock_i);
        mem_req_i = 1'b0;
        if (wr)
        begin
            chk("write address", ea, wr_addr_o);
            chk("write data", 20'(ed), 20'(wr_data_o));
        end
    endtask : oper

    // ==========================================================
    // main sequence
    initial
    begin
        int i;
        repeat (8) @(negedge clock_i);
        rst_n_i = 1'b1;
        #1;
        chk("pointer", 20'h0, 20'(fetch_pointer_o));
        chk("status", 20'h0f000, 20'(status_word_o));
        chk("queue count", 20'h0, 20'(queue_count_o));
        // stream crosses the top of memory and wraps to zero
        wait_i = 4'h2;
        take_bytes(8'hf0, 24);
        // odd jump under slow memory: flush, stall, restart on lane 1
        wait_i = 4'h6;
        @(negedge clock_i);
        jump_ofs_i = 16'h1235;
        jump_i = 1'b1;
        @(negedge clock_i);
        jump_i = 1'b0;
        chk("valid after jump", 20'h0, 20'(op_byte_valid_o));
        take_bytes(8'h25, 6);
        // operand cycles through every offset source
        wait_i = 4'h0;
        exec(CPAG_ALU_MOV, CPAG_R_BASE, 1'b0, 16'hfff8);
        exec(CPAG_ALU_MOV, CPAG_R_SRC, 1'b0, 16'h0100);
        @(negedge clock_i);
        seg_wr_i = 1'b1;
        seg_sel_i = CPAG_SEG_DATA;
        seg_wdata_i = 16'hffff;
        @(negedge clock_i);
        seg_wr_i = 1'b0;
        for (i = 0; i < 4; i++)
            oper(1'b1, 2'(i), CPAG_R_BASE, 20'hffff0 + 20'(ofs[i]),
                 16'hfff8);
        // read back through the alu bus, then write it out
        oper(1'b0, CPAG_OFS_REG, CPAG_R_CNT, 20'h0, 16'h0);
        oper(1'b1, CPAG_OFS_REG, CPAG_R_CNT, 20'h0ffe8, 16'he9e8);
        // word add with carry out, byte add on the low half only
        exec(CPAG_ALU_ADD, CPAG_R_BASE, 1'b0, 16'h0010);
        chk("carry flag", 20'h1, 20'(status_word_o[0]));
        exec(CPAG_ALU_ADD, CPAG_R_CNT, 1'b1, 16'h00ff);
        oper(1'b1, CPAG_OFS_REG, CPAG_R_BASE, 20'hffff8, 16'h0008);
        oper(1'b1, CPAG_OFS_REG, CPAG_R_CNT, 20'hffff8, 16'he9e7);
        // word subtract down to zero sets the zero flag
        exec(CPAG_ALU_SUB, CPAG_R_CNT, 1'b0, 16'he9e7);
        chk("zero flag", 20'h1, 20'(status_word_o[6]));
        // nobody takes bytes: queue fills up to its stop level
        for (i = 0; i < 400 && queue_count_o < 6'h1e; i++)
            @(negedge clock_i);
        bound(i, 400);
        results();
    end
endmodule : cpu_prefetch_and_address_gen_bench
`default_nettype wire
